// >>> rtl/cdec_decoder.sv
// compact halfword instruction decoder expanding to full-width operations
//
// Function
// - compact instructions start on any even address
// - register copy has two full 5-bit registers
// - word load/store offsets shifted left two
// - branch offset shifted one; uncond has 10 bits
// - same-register add: 5-bit reg, 4-bit immediate
// - stack adjust add: implicit stack pointer, 9-bit
// - two-register add: 3-bit regs, 3-bit immediate
// - stack-to-register add: 3-bit dest, 6-bit immediate
// - copy of zero to zero is no-op
// - subtract with zero first operand is negate
// - breakpoints: 4-bit code, 6-bit minor, one halfword
// - length decided by first major opcode only
// - first halfword upper in big, lower little; pc bit 1 swaps them
// - 5-bit fields linear; 3-bit fields mapped
`timescale 1ns/1ps
module cdec_decoder
    import cdec_pkg::*;
#(
    // 3-bit register field to register number map, entry n at bits 5n+4..5n
    parameter logic [39:0] REG3_MAP = 40'h39_8a41_8820
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire cdec_fetch_t fetchIn,
    output cdec_dec_t decOut
);

    ////////////////////////////////////////////////////////////////////////////
    // halfword selection and field extraction

    logic [15:0] half; // first halfword of the instruction
    logic [5:0] major; // major opcode
    logic isCompact; // length of the instruction
    logic upperFirst; // take bits 31..16

    // narrow register field lookup
    function automatic logic [4:0] map3(input logic [2:0] f);
        map3 = REG3_MAP[f*5 +: 5];
    endfunction

    always_comb begin
        upperFirst = fetchIn.bigEndian ^ fetchIn.pc[1];
        half = upperFirst ? fetchIn.word[31:16] : fetchIn.word[15:0];
        major = half[CDEC_MAJ_HI:CDEC_MAJ_LO];
        isCompact = (major[2:0] >= CDEC_CMP_LO) && (major[2:0] <= CDEC_CMP_HI);
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode of the compact forms

    cdec_dec_t dec_d; // next decoded output
    cdec_dec_t dec_q; // registered decoded output

    always_comb begin
        dec_d = '0;
        dec_d.valid = fetchIn.valid;
        dec_d.compact = isCompact;
        dec_d.firstHalf = half;
        dec_d.pc = fetchIn.pc;
        dec_d.op = isCompact ? CDEC_OP_RESERVED : CDEC_OP_WIDE;
        if (isCompact) begin
            case (major)
                CDEC_MAJ_REG_COPY: begin
                    dec_d.rd = half[9:5];
                    dec_d.rs = half[4:0];
                    dec_d.rt = CDEC_REG_ZERO;
                    // zero to zero is a no-op
                    if (half[9:5] == CDEC_REG_ZERO && half[4:0] == CDEC_REG_ZERO) begin
                        dec_d.op = CDEC_OP_NOP;
                    end else begin
                        dec_d.op = CDEC_OP_ADDU;
                    end
                end
                // three-register add and subtract
                CDEC_MAJ_POOL_A: begin
                    dec_d.rs = map3(half[9:7]);
                    dec_d.rt = map3(half[6:4]);
                    dec_d.rd = map3(half[3:1]);
                    if (half[0] == CDEC_MIN_SUB) begin
                        dec_d.op = CDEC_OP_SUBU;
                        dec_d.negate = (map3(half[9:7]) == CDEC_REG_ZERO);
                    end else begin
                        dec_d.op = CDEC_OP_ADDU;
                    end
                end
                // breakpoint pool
                CDEC_MAJ_POOL_C: begin
                    dec_d.code = half[9:6];
                    if (half[5:0] == CDEC_MIN_BREAK) begin
                        dec_d.op = CDEC_OP_BREAK;
                    end else if (half[5:0] == CDEC_MIN_DEBUG_BREAK) begin
                        dec_d.op = CDEC_OP_DEBUG_BREAK;
                    end else begin
                        dec_d.op = CDEC_OP_RESERVED;
                    end
                end
                // same-register and stack-adjust adds
                CDEC_MAJ_POOL_D: begin
                    dec_d.op = CDEC_OP_ADDIU;
                    if (half[0] == CDEC_MIN_SAME_REG) begin
                        // one register as source and dest
                        dec_d.rd = half[9:5];
                        dec_d.rs = half[9:5];
                        dec_d.imm = {{28{half[4]}}, half[4:1]};
                    end else begin
                        dec_d.rd = CDEC_REG_STACK_PTR;
                        dec_d.rs = CDEC_REG_STACK_PTR;
                        dec_d.imm = {{23{half[9]}}, half[9:1]};
                    end
                end
                // two-register and stack-to-register adds
                CDEC_MAJ_POOL_E: begin
                    dec_d.op = CDEC_OP_ADDIU;
                    dec_d.rd = map3(half[9:7]);
                    if (half[0] == CDEC_MIN_TWO_REG) begin
                        dec_d.rs = map3(half[6:4]);
                        dec_d.imm = {{29{half[3]}}, half[3:1]};
                    end else begin
                        dec_d.rs = CDEC_REG_STACK_PTR;
                        dec_d.imm = {26'h0, half[6:1]};
                    end
                end
                CDEC_MAJ_LOAD_WORD, CDEC_MAJ_STORE_WORD: begin
                    dec_d.op = (major == CDEC_MAJ_LOAD_WORD) ? CDEC_OP_LW : CDEC_OP_SW;
                    dec_d.rt = map3(half[9:7]);
                    dec_d.rs = map3(half[6:4]);
                    dec_d.imm = {26'h0, half[3:0], 2'h0};
                end
                CDEC_MAJ_LOAD_STACK, CDEC_MAJ_STORE_STACK: begin
                    dec_d.op = (major == CDEC_MAJ_LOAD_STACK) ? CDEC_OP_LW : CDEC_OP_SW;
                    dec_d.rt = half[9:5];
                    dec_d.rs = CDEC_REG_STACK_PTR;
                    dec_d.imm = {25'h0, half[4:0], 2'h0};
                end
                CDEC_MAJ_UNCOND_BR: begin
                    dec_d.op = CDEC_OP_BRANCH;
                    dec_d.imm = {{21{half[9]}}, half[9:0], 1'h0};
                end
                // other compact encodings are out of scope
                default: begin
                    dec_d.op = CDEC_OP_RESERVED;
                end
            endcase
        end
    end

    // output register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dec_q <= '0;
        end else begin
            dec_q <= dec_d;
        end
    end

    assign decOut = dec_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // a compact halfword taken with the given major
    sequence s_major(logic [5:0] m);
        fetchIn.valid && isCompact && major == m;
    endsequence

    property p_length;
        @(posedge core_clk) disable iff (!rst_b)
        fetchIn.valid |=> decOut.valid && decOut.compact ==
            ($past(major[2:0]) >= CDEC_CMP_LO && $past(major[2:0]) <= CDEC_CMP_HI);
    endproperty
    a_length: assert property (p_length) else $error("length not from major");

    property p_endian;
        @(posedge core_clk) disable iff (!rst_b)
        fetchIn.valid |=> decOut.firstHalf == (($past(fetchIn.bigEndian) ^ $past(fetchIn.pc[1]))
            ? $past(fetchIn.word[31:16]) : $past(fetchIn.word[15:0]));
    endproperty
    a_endian: assert property (p_endian) else $error("wrong halfword taken");

    property p_copy;
        @(posedge core_clk) disable iff (!rst_b)
        s_major(CDEC_MAJ_REG_COPY) |=> decOut.rd == $past(half[9:5])
            && decOut.rs == $past(half[4:0]);
    endproperty
    a_copy: assert property (p_copy) else $error("copy registers wrong");

    property p_nop;
        @(posedge core_clk) disable iff (!rst_b)
        s_major(CDEC_MAJ_REG_COPY) ##1 (decOut.rd == CDEC_REG_ZERO && decOut.rs == CDEC_REG_ZERO)
            |-> decOut.op == CDEC_OP_NOP;
    endproperty
    a_nop: assert property (p_nop) else $error("zero copy not a no-op");

    property p_word_scale;
        @(posedge core_clk) disable iff (!rst_b)
        (decOut.valid && decOut.compact && (decOut.op == CDEC_OP_LW || decOut.op == CDEC_OP_SW))
            |-> decOut.imm[1:0] == 2'h0;
    endproperty
    a_word_scale: assert property (p_word_scale) else $error("word offset unscaled");

    property p_stack_rel;
        @(posedge core_clk) disable iff (!rst_b)
        s_major(CDEC_MAJ_LOAD_STACK) |=> decOut.rs == CDEC_REG_STACK_PTR
            && decOut.imm == {25'h0, $past(half[4:0]), 2'h0};
    endproperty
    a_stack_rel: assert property (p_stack_rel) else $error("stack load wrong");

    property p_branch;
        @(posedge core_clk) disable iff (!rst_b)
        s_major(CDEC_MAJ_UNCOND_BR) |=> decOut.op == CDEC_OP_BRANCH
            && decOut.imm[10:0] == {$past(half[9:0]), 1'h0} && decOut.imm[31] == $past(half[9]);
    endproperty
    a_branch: assert property (p_branch) else $error("branch offset wrong");

    property p_stack_adj;
        @(posedge core_clk) disable iff (!rst_b)
        s_major(CDEC_MAJ_POOL_D) ##0 half[0] |=> decOut.rd == CDEC_REG_STACK_PTR
            && decOut.rs == CDEC_REG_STACK_PTR && decOut.imm[8:0] == $past(half[9:1]);
    endproperty
    a_stack_adj: assert property (p_stack_adj) else $error("stack adjust wrong");

    property p_negate;
        @(posedge core_clk) disable iff (!rst_b)
        s_major(CDEC_MAJ_POOL_A) ##0 half[0] |=> decOut.op == CDEC_OP_SUBU
            && decOut.negate == (decOut.rs == CDEC_REG_ZERO);
    endproperty
    a_negate: assert property (p_negate) else $error("negate flag wrong");

    property p_break;
        @(posedge core_clk) disable iff (!rst_b)
        s_major(CDEC_MAJ_POOL_C) ##0 (half[5:0] == CDEC_MIN_BREAK)
            |=> decOut.op == CDEC_OP_BREAK && decOut.code == $past(half[9:6]);
    endproperty
    a_break: assert property (p_break) else $error("breakpoint decode wrong");

    property p_same_reg;
        @(posedge core_clk) disable iff (!rst_b)
        s_major(CDEC_MAJ_POOL_D) ##0 !half[0] |=> decOut.rd == $past(half[9:5])
            && decOut.rs == $past(half[9:5]) && decOut.imm[3:0] == $past(half[4:1]);
    endproperty
    a_same_reg: assert property (p_same_reg) else $error("same register add wrong");

    property p_stack_to_reg;
        @(posedge core_clk) disable iff (!rst_b)
        s_major(CDEC_MAJ_POOL_E) ##0 half[0] |=> decOut.rs == CDEC_REG_STACK_PTR
            && decOut.imm == {26'h0, $past(half[6:1])};
    endproperty
    a_stack_to_reg: assert property (p_stack_to_reg) else $error("stack add wrong");

endmodule

// >>> rtl/cdec_pkg.sv
// package with encodings, field positions and carriers of the compact decoder
package cdec_pkg;

    // widths of the fetched word and the halfword parcel
    localparam int CDEC_WORD_W = 32;
    localparam int CDEC_HALF_W = 16;
    localparam int CDEC_REG_W = 5;

    // major opcode position inside the first halfword
    localparam int CDEC_MAJ_HI = 15;
    localparam int CDEC_MAJ_LO = 10;

    // major opcodes whose low three bits fall in this range are compact
    localparam logic [2:0] CDEC_CMP_LO = 3'h1;
    localparam logic [2:0] CDEC_CMP_HI = 3'h3;

    // major opcodes of the compact forms handled here
    localparam logic [5:0] CDEC_MAJ_REG_COPY = 6'h03;
    localparam logic [5:0] CDEC_MAJ_POOL_A = 6'h01;
    localparam logic [5:0] CDEC_MAJ_POOL_C = 6'h11;
    localparam logic [5:0] CDEC_MAJ_POOL_D = 6'h13;
    localparam logic [5:0] CDEC_MAJ_POOL_E = 6'h1b;
    localparam logic [5:0] CDEC_MAJ_LOAD_WORD = 6'h1a;
    localparam logic [5:0] CDEC_MAJ_STORE_WORD = 6'h3a;
    localparam logic [5:0] CDEC_MAJ_LOAD_STACK = 6'h12;
    localparam logic [5:0] CDEC_MAJ_STORE_STACK = 6'h32;
    localparam logic [5:0] CDEC_MAJ_UNCOND_BR = 6'h33;

    // minor opcodes inside the pools
    localparam logic CDEC_MIN_ADD = 1'h0;
    localparam logic CDEC_MIN_SUB = 1'h1;
    localparam logic CDEC_MIN_SAME_REG = 1'h0;
    localparam logic CDEC_MIN_STACK_ADJ = 1'h1;
    localparam logic CDEC_MIN_TWO_REG = 1'h0;
    localparam logic CDEC_MIN_STACK_REG = 1'h1;
    localparam logic [5:0] CDEC_MIN_BREAK = 6'h1b;
    localparam logic [5:0] CDEC_MIN_DEBUG_BREAK = 6'h3b;

    // implicit register numbers
    localparam logic [4:0] CDEC_REG_ZERO = 5'h00;
    localparam logic [4:0] CDEC_REG_STACK_PTR = 5'h1d;

    // offset scaling: word accesses by two places, branches by one
    localparam int CDEC_WORD_SHIFT = 2;
    localparam int CDEC_BR_SHIFT = 1;

    // reset value of the decoded immediate
    localparam logic [31:0] CDEC_IMM_RST = 32'h0000_0000;

    // internal operation handed to execute
    typedef enum logic [3:0] {
        CDEC_OP_NOP = 4'h0,
        CDEC_OP_ADDU = 4'h1,
        CDEC_OP_SUBU = 4'h2,
        CDEC_OP_ADDIU = 4'h3,
        CDEC_OP_LW = 4'h4,
        CDEC_OP_SW = 4'h5,
        CDEC_OP_BRANCH = 4'h6,
        CDEC_OP_BREAK = 4'h7,
        CDEC_OP_DEBUG_BREAK = 4'h8,
        CDEC_OP_WIDE = 4'h9,
        CDEC_OP_RESERVED = 4'ha
    } cdec_op_t;

    // fetch side parcel
    typedef struct packed {
        logic valid;
        logic bigEndian;
        logic [31:0] pc;
        logic [31:0] word;
    } cdec_fetch_t;

    // decoded operation towards execute
    typedef struct packed {
        logic valid;
        logic compact;
        logic negate;
        cdec_op_t op;
        logic [4:0] rd;
        logic [4:0] rs;
        logic [4:0] rt;
        logic [31:0] imm;
        logic [3:0] code;
        logic [15:0] firstHalf;
        logic [31:0] pc;
    } cdec_dec_t;

endpackage

// >>> verif/cdec_fetch_model.sv
// fetch stage model that packs instruction halfwords into aligned words
`timescale 1ns/1ps
module cdec_fetch_model
    import cdec_pkg::*;
(
    input wire logic valid,
    input wire logic bigEndian,
    input wire logic [31:0] pc,
    input wire logic [15:0] firstHalf,
    output cdec_fetch_t fetchOut
);
    // other slot carries the inverse so a wrong pick never decodes alike
    // halfword slot placement
    always_comb begin
        fetchOut.valid = valid;
        fetchOut.bigEndian = bigEndian;
        fetchOut.pc = pc;
        if (bigEndian ^ pc[1]) begin
            fetchOut.word = {firstHalf, ~firstHalf};
        end else begin
            fetchOut.word = {~firstHalf, firstHalf};
        end
    end
endmodule

// >>> verif/tb_top.sv
// self-checking bench of the compact decoder with random and corner halfwords
`timescale 1ns/1ps
module tb_top
    import cdec_pkg::*;
;
    // non-identity 3-bit register map, entry zero kept for the negate alias
    localparam logic [39:0] MAP = {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h11, 5'h00};
    localparam int LIMIT = 2000;
    localparam logic [15:0] CORNERS [16] = '{16'h0c22, 16'h0c00, 16'h0403, 16'h0475,
        16'h47db, 16'h443b, 16'h4c3e, 16'h4fff, 16'h4c01, 16'hcc00, 16'hcfff, 16'h4bff,
        16'h6fff, 16'h6ffe, 16'hebff, 16'hcbff};
    logic core_clk = 1'h0; // core clock, 50 ns period
    logic rst_b = 1'h0; // async reset, active low
    logic vIn = 1'h0; // offered parcel valid
    logic beIn = 1'h0; // big-endian mode
    logic [31:0] pcIn = 32'h0; // halfword address
    logic [15:0] halfIn = 16'h0; // instruction halfword
    cdec_fetch_t fetchIn; // packed parcel from the fetch model
    cdec_dec_t decOut; // decoded operation
    cdec_dec_t prevExp; // expectation of the last parcel
    cdec_dec_t prevMask; // fields that matter for it
    logic havePrev = 1'h0; // a parcel awaits judgement
    logic [31:0] rng = 32'h0001_793e;
    int nMismatch = 0;
    int nChecks = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////
    always #25 core_clk = ~core_clk;
    cdec_fetch_model fetchModel (.valid(vIn), .bigEndian(beIn), .pc(pcIn),
        .firstHalf(halfIn), .fetchOut(fetchIn));
    cdec_decoder #(.REG3_MAP(MAP)) DUT (.core_clk(core_clk), .rst_b(rst_b),
        .fetchIn(fetchIn), .decOut(decOut));
    ////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            nMismatch++;
            conclude();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'h0} ^ (s[31] ? 32'h0400_0007 : 32'h0);
    endfunction
    function automatic logic [4:0] map3(input logic [2:0] f);
        return MAP[f * 5 +: 5];
    endfunction
    // expected decode and the mask of meaningful fields
    function automatic void exp_dec(input logic v, input logic [31:0] pc,
        input logic [15:0] h, output cdec_dec_t e, output cdec_dec_t m);
        logic [5:0] mj;
        mj = h[15:10];
        e = '0;
        m = '1;
        e.valid = v;
        e.pc = pc;
        e.firstHalf = h;
        e.compact = (mj[2:0] >= 3'h1) && (mj[2:0] <= 3'h3);
        m.code = '0;
        if (!e.compact) begin
            // wide instruction: only valid, compact, pc, op and the first halfword matter
            e.op = CDEC_OP_WIDE;
            m.negate = 1'h0;
            m.rd = '0;
            m.rs = '0;
            m.rt = '0;
            m.imm = '0;
        end else begin
            case (mj)
                // register copy, zero to zero is the no-op
                CDEC_MAJ_REG_COPY: begin
                    e.op = (h[9:0] == 10'h0) ? CDEC_OP_NOP : CDEC_OP_ADDU;
                    e.rd = h[9:5];
                    e.rs = h[4:0];
                    m.imm = '0;
                end
                // three narrow registers, negate when first is zero
                CDEC_MAJ_POOL_A: begin
                    e.op = h[0] ? CDEC_OP_SUBU : CDEC_OP_ADDU;
                    e.rs = map3(h[9:7]);
                    e.rt = map3(h[6:4]);
                    e.rd = map3(h[3:1]);
                    e.negate = h[0] && (e.rs == 5'h00);
                    m.imm = '0;
                end
                // breakpoints carry a code only
                CDEC_MAJ_POOL_C: begin
                    e.code = h[9:6];
                    m.code = '1;
                    m.rd = '0;
                    m.rs = '0;
                    m.rt = '0;
                    m.imm = '0;
                    if (h[5:0] == CDEC_MIN_BREAK) begin
                        e.op = CDEC_OP_BREAK;
                    end else if (h[5:0] == CDEC_MIN_DEBUG_BREAK) begin
                        e.op = CDEC_OP_DEBUG_BREAK;
                    end else begin
                        e.op = CDEC_OP_RESERVED;
                    end
                end
                // same-register or stack adjust add
                CDEC_MAJ_POOL_D: begin
                    e.op = CDEC_OP_ADDIU;
                    m.rt = '0;
                    e.rd = h[0] ? CDEC_REG_STACK_PTR : h[9:5];
                    e.rs = e.rd;
                    e.imm = h[0] ? {{23{h[9]}}, h[9:1]} : {{28{h[4]}}, h[4:1]};
                end
                // two-register or stack-to-register add
                CDEC_MAJ_POOL_E: begin
                    e.op = CDEC_OP_ADDIU;
                    m.rt = '0;
                    e.rd = map3(h[9:7]);
                    e.rs = h[0] ? CDEC_REG_STACK_PTR : map3(h[6:4]);
                    e.imm = h[0] ? {26'h0, h[6:1]} : {{29{h[3]}}, h[3:1]};
                end
                // register-based word access, offset in words
                CDEC_MAJ_LOAD_WORD, CDEC_MAJ_STORE_WORD: begin
                    e.op = mj[5] ? CDEC_OP_SW : CDEC_OP_LW;
                    m.rd = '0;
                    e.rt = map3(h[9:7]);
                    e.rs = map3(h[6:4]);
                    e.imm = {26'h0, h[3:0], 2'h0};
                end
                // stack-relative word access, offset in words
                CDEC_MAJ_LOAD_STACK, CDEC_MAJ_STORE_STACK: begin
                    e.op = mj[5] ? CDEC_OP_SW : CDEC_OP_LW;
                    m.rd = '0;
                    e.rt = h[9:5];
                    e.rs = CDEC_REG_STACK_PTR;
                    e.imm = {25'h0, h[4:0], 2'h0};
                end
                // branch offset in halfwords
                CDEC_MAJ_UNCOND_BR: begin
                    e.op = CDEC_OP_BRANCH;
                    e.imm = {{21{h[9]}}, h[9:0], 1'h0};
                end
                // compact encodings outside this block
                default: begin
                    e.op = CDEC_OP_RESERVED;
                    m.negate = 1'h0;
                    m.rd = '0;
                    m.rs = '0;
                    m.rt = '0;
                    m.imm = '0;
                end
            endcase
        end
    endfunction
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [105:0] seen, input logic [105:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (nMismatch == 0 && nChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // offer one parcel and judge the one offered a cycle earlier
    task automatic step(input logic v, input logic be, input logic [31:0] pc,
        input logic [15:0] h);
        cdec_dec_t e;
        cdec_dec_t m;
        cdec_dec_t seenM;
        cdec_dec_t expM;
        @(posedge core_clk);
        vIn <= v;
        beIn <= be;
        pcIn <= pc;
        halfIn <= h;
        @(negedge core_clk);
        if (havePrev) begin
            seenM = decOut & prevMask;
            expM = prevExp & prevMask;
            check(seenM, expM);
            check({105'h0, decOut.compact}, {105'h0, prevExp.compact});
        end
        exp_dec(v, pc, h, e, m);
        prevExp = e;
        prevMask = m;
        havePrev = 1'h1;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        // decoded output stays cleared under reset
        repeat (2) begin
            @(negedge core_clk);
            check(decOut, '0);
        end
        @(posedge core_clk);
        rst_b <= 1'h1;
        // corner encodings back to back, both endians and slots
        for (int i = 0; i < 16; i++) begin
            rng = lfsr(rng);
            step(1'h1, i[0], {rng[31:2], i[1], 1'h0}, CORNERS[i]);
        end
        // every major opcode with random fields
        for (int mj = 0; mj < 64; mj++) begin
            repeat (4) begin
                rng = lfsr(rng);
                step(rng[0] | rng[1], rng[2], {rng[31:1], 1'h0}, {mj[5:0], rng[13:4]});
            end
        end
        step(1'h0, 1'h0, 32'h0, 16'h0);
        conclude();
    end
endmodule
